/* src/coc_pkg.sv */
package coc_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] OPT0_ADDR = 8'h12;
   localparam logic [7:0] CHG_CUR_ADDR = 8'h14;
   localparam logic [7:0] CHG_VOLT_ADDR = 8'h15;
   localparam logic [15:0] OPT0_RST_SMB = 16'he14e;
   localparam logic [15:0] OPT0_RST_I2C = 16'he34e;
   localparam logic [15:0] CHG_CUR_RST = 16'h0000;
   localparam logic [15:0] CHG_VOLT_RST = 16'h0000;
   // ==========================================
   // field positions of option control zero
   localparam int LOW_PWR_BIT = 15;
   localparam int WD_LSB = 13;
   localparam int AUTO_DIS_BIT = 12;
   localparam int OVP_BIT = 11;
   localparam int AUDIO_BIT = 10;
   localparam int FREQ_LSB = 8;
   localparam int INPUT_OVERCURRENT_PROTECT_BIT = 7;
   localparam int LSOC_BIT = 6;
   localparam int BATTERY_CALIBRATION_DISCHARGE_BIT = 5;
   localparam int ADP_GAIN_BIT = 4;
   localparam int BAT_GAIN_BIT = 3;
   localparam int RSVD_BIT = 2;
   localparam int IREG_EN_BIT = 1;
   localparam int INHIBIT_BIT = 0;
   // ==========================================
   // watchdog timing
   localparam int WD_44_S = 44;
   localparam int WD_88_S = 88;
   localparam int WD_175_S = 175;
   localparam int MS_PER_S = 1000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
   // ==========================================
   // analog settings
   localparam logic [10:0] FREQ_600_KHZ = 11'd600;
   localparam logic [10:0] FREQ_800_KHZ = 11'd800;
   localparam logic [10:0] FREQ_1000_KHZ = 11'd1000;
   localparam logic [10:0] FREQ_1200_KHZ = 11'd1200;
   localparam logic [5:0] AUDIO_MIN_KHZ = 6'd40;
   localparam logic [8:0] INPUT_OVERCURRENT_PROTECT_PCT = 9'd300;
   localparam logic [8:0] LSOC_LOW_MV = 9'd170;
   localparam logic [8:0] LSOC_HIGH_MV = 9'd290;
   localparam logic [6:0] ADP_GAIN_LO = 7'd40;
   localparam logic [6:0] ADP_GAIN_HI = 7'd80;
   localparam logic [6:0] BAT_GAIN_LO = 7'd8;
   localparam logic [6:0] BAT_GAIN_HI = 7'd16;
   // ==========================================
   // register access carriers
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [15:0] wdata;
   } coc_req_t;
   typedef struct packed {
      logic ack;
      logic nack;
      logic [15:0] rdata;
   } coc_rsp_t;
endpackage

/* src/coc_option_zero.sv */
`timescale 1ns/1ns
`default_nettype none
module coc_option_zero #(
   parameter bit I2C_VARIANT = 1'b0,
   parameter int TICK_CYC = coc_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire coc_pkg::coc_req_t req,
   input wire logic ext_reg_hit,
   output coc_pkg::coc_rsp_t rsp,
   input wire logic battery_only,
   input wire logic battery_present_input,
   input wire logic system_overvoltage,
   input wire logic adapter_present,
   input wire logic processor_hot_output_cfg_en,
   input wire logic bat_mon_cfg_en,
   input wire logic pwr_mon_cfg_en,
   input wire logic cmp_cfg_en,
   output logic processor_hot_output_en,
   output logic battery_current_monitor_en,
   output logic power_monitor_en,
   output logic comparator_en,
   output logic [10:0] switch_freq_khz,
   output logic [5:0] min_freq_khz,
   output logic [8:0] input_overcurrent_protect_pct,
   output logic [8:0] low_side_switch_limit_mv,
   output logic [6:0] adapter_current_monitor_gain,
   output logic [6:0] battery_current_monitor_gain,
   output logic input_current_regulation_on,
   output logic buck_run,
   output logic adapter_switch_on,
   output logic reverse_blocking_switch_on,
   output logic battery_switch_on,
   output logic charge_enable,
   output logic watchdog_expired,
   output logic [15:0] charge_current_setting,
   output logic [15:0] charge_voltage_limit
);
   localparam logic [15:0] OPT0_RST =
      I2C_VARIANT ? coc_pkg::OPT0_RST_I2C : coc_pkg::OPT0_RST_SMB;
   localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

   // ==========================================
   // decode helpers
   function automatic logic [17:0] wd_limit_ms(input logic [1:0] sel);
      case (sel)
         2'b01: wd_limit_ms = 18'(coc_pkg::WD_44_S * coc_pkg::MS_PER_S);
         2'b10: wd_limit_ms = 18'(coc_pkg::WD_88_S * coc_pkg::MS_PER_S);
         2'b11: wd_limit_ms = 18'(coc_pkg::WD_175_S * coc_pkg::MS_PER_S);
         default: wd_limit_ms = 18'h00000;
      endcase
   endfunction

   logic [15:0] opt_ff;
   logic [15:0] cur_ff;
   logic [15:0] volt_ff;
   logic bp_ff;
   logic wd_exp_ff;
   logic [16:0] tick_ff;
   logic [17:0] ms_ff;
   logic wr_opt;
   logic wr_cur;
   logic wr_volt;
   logic own_hit;
   logic bp_rise;
   logic wd_on;
   logic wd_fire;
   logic [15:0] opt_view;

   // ==========================================
   // access decode
   always_comb begin
      own_hit = 1'b0;
      if (req.addr == coc_pkg::OPT0_ADDR) begin
         own_hit = 1'b1;
      end else if (req.addr == coc_pkg::CHG_CUR_ADDR) begin
         own_hit = 1'b1;
      end else if (req.addr == coc_pkg::CHG_VOLT_ADDR) begin
         own_hit = 1'b1;
      end
   end
   assign wr_opt = req_valid && req.write && req.addr == coc_pkg::OPT0_ADDR;
   assign wr_cur = req_valid && req.write &&
      req.addr == coc_pkg::CHG_CUR_ADDR;
   assign wr_volt = req_valid && req.write &&
      req.addr == coc_pkg::CHG_VOLT_ADDR;
   assign bp_rise = battery_present_input && !bp_ff;
   assign wd_on = opt_ff[coc_pkg::WD_LSB +: 2] != 2'b00;
   // at or past the limit, so a shorter period picked mid-count still fires
   assign wd_fire = wd_on && !wd_exp_ff && tick_ff == TICK_LAST &&
      ms_ff >= wd_limit_ms(opt_ff[coc_pkg::WD_LSB +: 2]) - 18'h00001;
   // reserved bit always seen as one
   always_comb begin
      opt_view = opt_ff;
      opt_view[coc_pkg::RSVD_BIT] = 1'b1;
   end

   // ==========================================
   // answer to the bus engine, one cycle after the request
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rsp <= '0;
      end else begin
         rsp.ack <= req_valid && (own_hit || ext_reg_hit);
         rsp.nack <= req_valid && !own_hit && !ext_reg_hit;
         rsp.rdata <= 16'h0000;
         if (req_valid && !req.write) begin
            if (req.addr == coc_pkg::OPT0_ADDR) begin
               rsp.rdata <= opt_view;
            end else if (req.addr == coc_pkg::CHG_CUR_ADDR) begin
               rsp.rdata <= cur_ff;
            end else if (req.addr == coc_pkg::CHG_VOLT_ADDR) begin
               rsp.rdata <= volt_ff;
            end
         end
      end
   end

   // ==========================================
   // option control zero register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         opt_ff <= OPT0_RST;
      end else begin
         if (wr_opt) begin
            opt_ff <= req.wdata;
            opt_ff[coc_pkg::RSVD_BIT] <= 1'b1;
            // status bit: a write of 0 clears it, a write of 1 cannot set it
            opt_ff[coc_pkg::OVP_BIT] <= opt_ff[coc_pkg::OVP_BIT] &&
               req.wdata[coc_pkg::OVP_BIT];
         end
         // adapter unplug clears the latch
         if (!adapter_present) begin
            opt_ff[coc_pkg::OVP_BIT] <= 1'b0;
         end
         // detection beats any clear
         if (system_overvoltage) begin
            opt_ff[coc_pkg::OVP_BIT] <= 1'b1;
         end
         // automatic disable beats a host write
         if (opt_ff[coc_pkg::AUTO_DIS_BIT] && bp_rise) begin
            opt_ff[coc_pkg::IREG_EN_BIT] <= 1'b0;
         end
      end
   end

   // battery present edge history
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bp_ff <= 1'b0;
      end else begin
         bp_ff <= battery_present_input;
      end
   end

   // ==========================================
   // charge current and voltage limit settings
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cur_ff <= coc_pkg::CHG_CUR_RST;
         volt_ff <= coc_pkg::CHG_VOLT_RST;
      end else begin
         if (wr_volt) begin
            volt_ff <= req.wdata;
         end
         if (wd_fire) begin
            cur_ff <= 16'h0000;
         end else if (wr_cur) begin
            cur_ff <= req.wdata;
         end
      end
   end

   // ==========================================
   // watchdog: millisecond prescaler and period counter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_ff <= '0;
         ms_ff <= '0;
         wd_exp_ff <= 1'b0;
      end else begin
         if (wd_fire) begin
            wd_exp_ff <= 1'b1;
         end else if (wr_cur || wr_volt || !wd_on) begin
            wd_exp_ff <= 1'b0;
            tick_ff <= '0;
            ms_ff <= '0;
         end else if (!wd_exp_ff) begin
            if (tick_ff == TICK_LAST) begin
               tick_ff <= '0;
               ms_ff <= ms_ff + 18'h00001;
            end else begin
               tick_ff <= tick_ff + 17'h00001;
            end
         end
      end
   end
   assign watchdog_expired = wd_exp_ff;

   // ==========================================
   // enables of the monitors in low power mode
   always_comb begin
      processor_hot_output_en = processor_hot_output_cfg_en;
      battery_current_monitor_en = bat_mon_cfg_en;
      power_monitor_en = pwr_mon_cfg_en;
      comparator_en = cmp_cfg_en;
      if (opt_ff[coc_pkg::LOW_PWR_BIT] && battery_only) begin
         processor_hot_output_en = 1'b0;
         battery_current_monitor_en = 1'b0;
         power_monitor_en = 1'b0;
         comparator_en = 1'b0;
      end
   end

   // ==========================================
   // converter and protection settings
   always_comb begin
      case (opt_ff[coc_pkg::FREQ_LSB +: 2])
         2'b00: switch_freq_khz = coc_pkg::FREQ_600_KHZ;
         2'b01: switch_freq_khz = coc_pkg::FREQ_800_KHZ;
         2'b10: switch_freq_khz = coc_pkg::FREQ_1000_KHZ;
         default: switch_freq_khz = coc_pkg::FREQ_1200_KHZ;
      endcase
   end
   // zero means no lower bound
   assign min_freq_khz = opt_ff[coc_pkg::AUDIO_BIT] ?
      coc_pkg::AUDIO_MIN_KHZ : 6'h00;
   assign input_overcurrent_protect_pct = opt_ff[coc_pkg::INPUT_OVERCURRENT_PROTECT_BIT] ?
      coc_pkg::INPUT_OVERCURRENT_PROTECT_PCT : 9'h000;
   assign low_side_switch_limit_mv = opt_ff[coc_pkg::LSOC_BIT] ?
      coc_pkg::LSOC_HIGH_MV : coc_pkg::LSOC_LOW_MV;
   assign adapter_current_monitor_gain = opt_ff[coc_pkg::ADP_GAIN_BIT] ?
      coc_pkg::ADP_GAIN_HI : coc_pkg::ADP_GAIN_LO;
   assign battery_current_monitor_gain = opt_ff[coc_pkg::BAT_GAIN_BIT] ?
      coc_pkg::BAT_GAIN_HI : coc_pkg::BAT_GAIN_LO;
   assign input_current_regulation_on =
      opt_ff[coc_pkg::IREG_EN_BIT];

   // ==========================================
   // power path and charging
   assign buck_run = !opt_ff[coc_pkg::BATTERY_CALIBRATION_DISCHARGE_BIT];
   assign battery_switch_on = opt_ff[coc_pkg::BATTERY_CALIBRATION_DISCHARGE_BIT];
   // overvoltage latch opens both input switches, independent of battery_calibration_discharge mode
   assign adapter_switch_on = !opt_ff[coc_pkg::OVP_BIT];
   assign reverse_blocking_switch_on = !opt_ff[coc_pkg::OVP_BIT];
   assign charge_enable = !opt_ff[coc_pkg::INHIBIT_BIT] &&
      !opt_ff[coc_pkg::BATTERY_CALIBRATION_DISCHARGE_BIT] && cur_ff != 16'h0000;
   assign charge_current_setting = cur_ff;
   assign charge_voltage_limit = volt_ff;

   // ==========================================
   // checks
   low_power_gate_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      opt_ff[coc_pkg::LOW_PWR_BIT] && battery_only |->
      !processor_hot_output_en && !comparator_en && !power_monitor_en &&
      !battery_current_monitor_en)
      else $error("low power mode left an enable on");
   perf_follow_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !opt_ff[coc_pkg::LOW_PWR_BIT] |->
      battery_current_monitor_en == bat_mon_cfg_en)
      else $error("monitor enable ignores its config bit");
   wd_zero_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wd_fire |=> charge_current_setting == 16'h0000 && watchdog_expired)
      else $error("watchdog expiry did not zero charge current");
   wd_restart_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      watchdog_expired && (wr_cur || wr_volt) |=>
      !watchdog_expired && ms_ff == 18'h00000)
      else $error("watchdog did not restart on write");
   auto_dis_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $rose(battery_present_input) && opt_ff[coc_pkg::AUTO_DIS_BIT]
      |=> !input_current_regulation_on)
      else $error("input regulation not auto disabled");
   ovp_latch_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      system_overvoltage |=> !adapter_switch_on &&
      !reverse_blocking_switch_on && opt_ff[coc_pkg::OVP_BIT])
      else $error("overvoltage did not latch switches off");
   ovp_unplug_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !adapter_present && !system_overvoltage |=> adapter_switch_on)
      else $error("unplug did not clear overvoltage latch");
   battery_calibration_discharge_stop_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      opt_ff[coc_pkg::BATTERY_CALIBRATION_DISCHARGE_BIT] |->
      !buck_run && battery_switch_on && !charge_enable)
      else $error("battery_calibration_discharge mode power path mismatch");
   inhibit_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      opt_ff[coc_pkg::INHIBIT_BIT] || cur_ff == 16'h0000 |-> !charge_enable)
      else $error("charging while inhibited or zero current");
   unmapped_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      req_valid && !own_hit && !ext_reg_hit |=> rsp.nack && !rsp.ack)
      else $error("unmapped address not refused");
   rsvd_one_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      req_valid && !req.write && req.addr == coc_pkg::OPT0_ADDR
      |=> rsp.rdata[coc_pkg::RSVD_BIT])
      else $error("reserved bit read as zero");
endmodule
`default_nettype wire

/* verification/coc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// host side: one register request at a time
module coc_host_model (
   input wire logic sys_clk,
   input wire coc_pkg::coc_rsp_t rsp,
   output logic req_valid,
   output coc_pkg::coc_req_t req,
   output logic ext_reg_hit
);
   // idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req = '0;
      ext_reg_hit = 1'b0;
   end
   // request held one cycle, answer taken after the next edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [15:0] d, input logic x, output logic [15:0] rd,
      output logic ack, output logic nack);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{write: w, addr: a, wdata: d};
      ext_reg_hit <= x;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      req <= coc_pkg::coc_req_t'(~req); // stale fields scrambled
      ext_reg_hit <= 1'b0;
      #1;
      rd = rsp.rdata;
      ack = rsp.ack;
      nack = rsp.nack;
   endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ==========================================
   // signals
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid, ext_reg_hit, ack, nack, lp;
   coc_pkg::coc_req_t req;
   coc_pkg::coc_rsp_t rsp;
   logic bonly = 1'b0, bpres = 1'b0, ovp = 1'b0, adp = 1'b1;
   logic [3:0] cfg = 4'h0;
   logic hot, bmon, pmon, cmpe, icr, buck, asw, rsw, bsw, chg, wde;
   logic [10:0] fq;
   logic [5:0] mf;
   logic [8:0] oc, ls;
   logic [6:0] ag, bg;
   logic [15:0] cur, vlt, rd, opt, curx, d;
   logic [15:0] ftab [4] = '{16'h258, 16'h320, 16'h3e8, 16'h4b0};
   int n_errors = 0;
   int num_checks = 0;
   int n;
   // 8 ns clock
   always #4 sys_clk = ~sys_clk;
   // ==========================================
   // design and host
   coc_option_zero #(.I2C_VARIANT(1'b0), .TICK_CYC(2)) coc_option_zero_inst (
      .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
      .req(req), .ext_reg_hit(ext_reg_hit), .rsp(rsp),
      .battery_only(bonly), .battery_present_input(bpres),
      .system_overvoltage(ovp), .adapter_present(adp),
      .processor_hot_output_cfg_en(cfg[0]), .bat_mon_cfg_en(cfg[1]),
      .pwr_mon_cfg_en(cfg[2]), .cmp_cfg_en(cfg[3]),
      .processor_hot_output_en(hot), .battery_current_monitor_en(bmon),
      .power_monitor_en(pmon), .comparator_en(cmpe),
      .switch_freq_khz(fq), .min_freq_khz(mf),
      .input_overcurrent_protect_pct(oc), .low_side_switch_limit_mv(ls),
      .adapter_current_monitor_gain(ag), .battery_current_monitor_gain(bg),
      .input_current_regulation_on(icr), .buck_run(buck),
      .adapter_switch_on(asw), .reverse_blocking_switch_on(rsw),
      .battery_switch_on(bsw), .charge_enable(chg), .watchdog_expired(wde),
      .charge_current_setting(cur), .charge_voltage_limit(vlt));
   coc_host_model coc_host_model_inst (.sys_clk(sys_clk), .rsp(rsp),
      .req_valid(req_valid), .req(req), .ext_reg_hit(ext_reg_hit));
   // ==========================================
   // helpers
   task automatic chk(input string nm, input logic [15:0] s,
      input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one request through the host model
   task automatic xf(input logic w, input logic [7:0] a,
      input logic [15:0] v, input logic x);
      coc_host_model_inst.xfer(w, a, v, x, rd, ack, nack);
   endtask
   // option write; bit 2 reads one, bit 11 only cleared by host
   task automatic wopt(input logic [15:0] v);
      xf(1'b1, coc_pkg::OPT0_ADDR, v, 1'b0);
      opt = (v & 16'hf7fb) | 16'h0004 | (v & opt & 16'h0800);
   endtask
   // readback and decoded outputs against the shadow value
   task automatic chk_all;
      lp = bonly & opt[15];
      xf(1'b0, coc_pkg::OPT0_ADDR, 16'h0, 1'b0);
      chk("opt", rd, opt);
      chk("freq", 16'(fq), ftab[opt[9:8]]);
      chk("minf", 16'(mf), opt[10] ? 16'h28 : 16'h0);
      chk("input_overcurrent_protect", 16'(oc), opt[7] ? 16'h12c : 16'h0);
      chk("lsoc", 16'(ls), opt[6] ? 16'h122 : 16'haa);
      chk("again", 16'(ag), opt[4] ? 16'h50 : 16'h28);
      chk("bgain", 16'(bg), opt[3] ? 16'h10 : 16'h8);
      chk("ireg", 16'(icr), 16'(opt[1]));
      chk("buck", 16'(buck), 16'(!opt[5]));
      chk("bsw", 16'(bsw), 16'(opt[5]));
      chk("asw", 16'({asw, rsw}), 16'({2{!opt[11]}}));
      chk("chg", 16'(chg), 16'(!opt[0] && !opt[5] && |curx));
      chk("hot", 16'(hot), 16'(cfg[0] && !lp));
      chk("mon", 16'({cmpe, pmon, bmon}), 16'(cfg[3:1] & {3{!lp}}));
      chk("cur", cur, curx);
   endtask
   // ==========================================
   // verdict
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (99000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish;
   end
   // ==========================================
   // tests
   initial begin
      n = $urandom(717);
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      opt = 16'he14e;
      curx = 16'h0;
      chk_all;
      $display("test reset done");
      // random option and setpoint writes, corners first
      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($urandom);
         @(posedge sys_clk);
         cfg <= 4'($urandom);
         bonly <= 1'($urandom);
         wopt(d);
         curx = 16'($urandom);
         xf(1'b1, coc_pkg::CHG_CUR_ADDR, curx, 1'b0);
         xf(1'b1, coc_pkg::CHG_VOLT_ADDR, ~curx, 1'b0);
         chk("volt", vlt, ~curx);
         chk_all;
      end
      $display("test random done");
      // undefined address refused, sibling address accepted
      xf(1'b1, 8'h13, 16'h0, 1'b0);
      chk("nack", 16'({ack, nack}), 16'h1);
      xf(1'b0, 8'h3b, 16'h0, 1'b1);
      chk("ext", 16'({ack, nack}), 16'h2);
      chk_all;
      $display("test address done");
      // battery-only low power versus performance mode
      @(posedge sys_clk);
      bonly <= 1'b1;
      cfg <= 4'hf;
      wopt(opt | 16'h8000);
      chk_all;
      wopt(opt & 16'h7fff);
      chk_all;
      $display("test low power done");
      // overvoltage latch, clear refused while present, then cleared
      @(posedge sys_clk);
      ovp <= 1'b1;
      opt[11] = 1'b1;
      chk_all;
      xf(1'b1, coc_pkg::OPT0_ADDR, opt & 16'hf7ff, 1'b0);
      chk_all;
      @(posedge sys_clk);
      ovp <= 1'b0;
      wopt(opt & 16'hf7ff);
      chk_all;
      // unplug clears a fresh latch
      @(posedge sys_clk);
      ovp <= 1'b1;
      @(posedge sys_clk);
      ovp <= 1'b0;
      adp <= 1'b0;
      #1;
      chk("latch", 16'({asw, rsw}), 16'h0);
      chk_all;
      @(posedge sys_clk);
      adp <= 1'b1;
      $display("test overvoltage done");
      // armed battery insertion drops input regulation
      wopt(opt | 16'h1002);
      @(posedge sys_clk);
      bpres <= 1'b1;
      opt[1] = 1'b0;
      chk_all;
      wopt(opt | 16'h0002);
      chk_all;
      $display("test auto disable done");
      // inhibit, then battery_calibration_discharge entry and exit
      wopt(opt | 16'h0001);
      curx = 16'h0100;
      xf(1'b1, coc_pkg::CHG_CUR_ADDR, curx, 1'b0);
      chk_all;
      wopt(opt & 16'hffde);
      xf(1'b1, coc_pkg::CHG_CUR_ADDR, curx, 1'b0);
      chk_all;
      wopt(opt | 16'h0020);
      chk_all;
      wopt(opt & 16'hffdf);
      chk_all;
      $display("test inhibit battery_calibration_discharge done");
      // 44 s watchdog expires, setpoint write restarts it
      wopt((opt & 16'h9fff) | 16'h2000);
      xf(1'b1, coc_pkg::CHG_CUR_ADDR, curx, 1'b0);
      n = 0;
      while (wde !== 1'b1 && n < 90000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("wdt", 16'(n > 87990 && n < 88010), 16'h1);
      curx = 16'h0;
      chk_all;
      curx = 16'h0180;
      xf(1'b1, coc_pkg::CHG_CUR_ADDR, curx, 1'b0);
      chk("wde", 16'(wde), 16'h0);
      chk_all;
      $display("test watchdog done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
